// [src/shsc_ctrl.sv]
/*
 * shsc_ctrl: standby controller (halt and stop) with an apb control port.
 * Assumes the core pulses instr_valid for one cycle per standby instruction
 * and that pclk is a free reference even while the oscillator enable is low.
 */
// Our own choices: the register offsets and the APB register port.
// Notes on behaviour
// - stop halts the oscillator until wake
// - halt gates only the processor clock
// - halt wake resumes at once, no wait
// - retain state except stop with zero operand
// - stop clears and blocks timer; halt runs
// - stop: serial only with external clock
// - comparator stops; undefined after halt
// - stop zero operand forces pins input
// - pending enabled source blocks standby entry; here only with operand bit3 set, or on a timer request with halt bit1
// - halt operand bit3 irq, bit1 timer
// - stop operand bit3 only; zero reinitialises
// - restart: zero, next, or vector
// - reset and stop wake wait 65536 cycles
`default_nettype none
module shsc_ctrl #(
    parameter int unsigned WAIT_CYCLES = shsc_pkg::WAIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire logic instr_valid,
    input wire logic instr_is_halt,
    input wire logic instr_is_stop,
    input wire logic [3:0] instr_operand,
    input wire logic [3:1] interrupt_request_flag,
    input wire logic [3:0] interrupt_permit_flag,
    input wire logic interrupts_enabled_state,
    input wire logic ext_int_pin,
    input wire logic ext_req_clear,
    input wire logic compare_done,
    output logic ext_req_flag_q,
    output logic osc_enable_q,
    output logic cpu_clk_enable_q,
    output logic timer_run_q,
    output logic timer_clear_q,
    output logic serial_run_q,
    output logic comparator_run_q,
    output logic comparator_undefined_q,
    output logic state_retain_q,
    output logic pins_input_q,
    output logic reinit_q,
    output logic resume_q,
    output logic [1:0] restart_kind_q,
    output logic [1:0] restart_vector_q
);
    logic [3:0] req;
    logic [3:0] pend;
    logic any_pend;
    logic ext_flag;
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    shsc_pkg::shsc_state_t state_q;
    shsc_pkg::shsc_state_t state_d;
    logic [3:0] op_q;
    logic [3:0] op_d;
    logic [shsc_pkg::CNT_W-1:0] cnt_q;
    logic [shsc_pkg::CNT_W-1:0] cnt_d;
    logic [1:0] kind_d;
    logic [1:0] vec_d;
    logic undef_d;
    logic resume_d;
    logic reinit_d;
    logic entry_req;
    logic entry_block;
    logic halt_wake;
    logic stop_wake;
    logic [31:0] prdata_d;
    logic pready_d;
    logic pslverr_d;

    // highest-priority pending source, index 0 first
    function automatic logic [1:0] shsc_prio(input logic [3:0] p);
        logic [1:0] r;
        r = 2'h0;
        for (int i = shsc_pkg::NREQ - 1; i >= 0; i--)
        begin
            if (p[i])
            begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : shsc_prio

    // -------------------------------------------------------------------
    // external pin request
    // -------------------------------------------------------------------
    shsc_edge shsc_edge_i (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_int_pin),
        .edge_sel(ctrl_q[shsc_pkg::CTRL_EDGE_LSB +: 2]),
        .clear(ext_req_clear),
        .flag_q(ext_flag)
    );

    // request set with the pin flag in the top-priority slot
    assign req = {interrupt_request_flag, ext_flag};
    assign pend = req & interrupt_permit_flag;
    assign any_pend = |pend;

    // -------------------------------------------------------------------
    // standby fsm
    // -------------------------------------------------------------------
    always_comb
    begin
        entry_req = instr_valid & (instr_is_halt | instr_is_stop);
        // the core's no-op before the instruction makes req current
        entry_block = (instr_operand[shsc_pkg::OP_IRQ_BIT] & any_pend)
            | (instr_is_halt & instr_operand[shsc_pkg::OP_TMR_BIT]
            & req[shsc_pkg::TIMER_IDX]);
        halt_wake = (op_q[shsc_pkg::OP_IRQ_BIT] & any_pend)
            | (op_q[shsc_pkg::OP_TMR_BIT] & req[shsc_pkg::TIMER_IDX]);
        stop_wake = op_q[shsc_pkg::OP_IRQ_BIT] & any_pend; // timer ignored
        state_d = state_q;
        op_d = op_q;
        cnt_d = '0;
        kind_d = restart_kind_q;
        vec_d = restart_vector_q;
        resume_d = 1'b0;
        reinit_d = 1'b0;
        undef_d = comparator_undefined_q & ~compare_done;
        // wake cause picks the restart point
        if (interrupts_enabled_state && any_pend)
        begin
            vec_d = shsc_prio(pend);
        end
        unique case (state_q)
            shsc_pkg::SHSC_RUN:
            begin
                if (entry_req && !entry_block)
                begin
                    op_d = instr_operand;
                    state_d = instr_is_stop ? shsc_pkg::SHSC_STOP : shsc_pkg::SHSC_HALT;
                    reinit_d = instr_is_stop && (instr_operand == shsc_pkg::OP_ZERO);
                end
            end
            shsc_pkg::SHSC_HALT:
            begin
                if (halt_wake)
                begin
                    state_d = shsc_pkg::SHSC_RUN; // no settle wait
                    resume_d = 1'b1;
                    undef_d = 1'b1;
                    kind_d = (interrupts_enabled_state && any_pend) ?
                        shsc_pkg::SHSC_RST_VEC : shsc_pkg::SHSC_RST_NEXT;
                end
            end
            shsc_pkg::SHSC_STOP:
            begin
                if (stop_wake)
                begin
                    state_d = shsc_pkg::SHSC_WAIT; // oscillator restarts
                    kind_d = interrupts_enabled_state ?
                        shsc_pkg::SHSC_RST_VEC : shsc_pkg::SHSC_RST_NEXT;
                end
            end
            shsc_pkg::SHSC_WAIT:
            begin
                cnt_d = shsc_pkg::CNT_W'(cnt_q + 1'b1);
                if (cnt_q == shsc_pkg::CNT_W'(WAIT_CYCLES - 1))
                begin
                    state_d = shsc_pkg::SHSC_RUN;
                    resume_d = 1'b1;
                    cnt_d = '0;
                end
            end
            default:
            begin
                state_d = shsc_pkg::SHSC_WAIT;
            end
        endcase
    end

    // fsm registers; reset starts in the settle wait with a zero restart
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= shsc_pkg::SHSC_WAIT;
            op_q <= shsc_pkg::OP_ZERO;
            cnt_q <= '0;
            restart_kind_q <= shsc_pkg::SHSC_RST_ZERO;
            restart_vector_q <= 2'h0;
            resume_q <= 1'b0;
            reinit_q <= 1'b0;
            comparator_undefined_q <= 1'b0;
            osc_enable_q <= 1'b1;
            cpu_clk_enable_q <= 1'b0;
            timer_run_q <= 1'b1;
            timer_clear_q <= 1'b0;
            serial_run_q <= 1'b0;
            comparator_run_q <= 1'b0;
            state_retain_q <= 1'b0;
            pins_input_q <= 1'b0;
            ext_req_flag_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            restart_kind_q <= kind_d;
            restart_vector_q <= vec_d;
            resume_q <= resume_d;
            reinit_q <= reinit_d;
            comparator_undefined_q <= undef_d;
            ext_req_flag_q <= ext_flag;
            osc_enable_q <= state_d != shsc_pkg::SHSC_STOP;
            cpu_clk_enable_q <= state_d == shsc_pkg::SHSC_RUN;
            timer_run_q <= state_d != shsc_pkg::SHSC_STOP;
            timer_clear_q <= state_d == shsc_pkg::SHSC_STOP;
            serial_run_q <= (state_d == shsc_pkg::SHSC_RUN) || (state_d == shsc_pkg::SHSC_HALT)
                || ((state_d == shsc_pkg::SHSC_STOP) && ctrl_q[shsc_pkg::CTRL_EXTCLK_BIT]);
            comparator_run_q <= state_d == shsc_pkg::SHSC_RUN;
            state_retain_q <= ((state_d == shsc_pkg::SHSC_HALT) || (state_d == shsc_pkg::SHSC_STOP))
                && (op_d != shsc_pkg::OP_ZERO || state_d == shsc_pkg::SHSC_HALT);
            pins_input_q <= (state_d == shsc_pkg::SHSC_STOP) && (op_d == shsc_pkg::OP_ZERO);
        end
    end

    // -------------------------------------------------------------------
    // apb slave: answer in the first access cycle
    // -------------------------------------------------------------------
    always_comb
    begin
        ctrl_d = ctrl_q;
        pready_d = psel & ~penable;
        pslverr_d = 1'b0;
        prdata_d = 32'h0;
        if (psel && !penable)
        begin
            if (paddr == shsc_pkg::CTRL_OFS)
            begin
                prdata_d = {29'h0, ctrl_q};
            end
            else if (paddr == shsc_pkg::STATUS_OFS)
            begin
                prdata_d = {20'h0, restart_vector_q, restart_kind_q, op_q, state_q};
            end
            else
            begin
                pslverr_d = 1'b1; // unmapped: error, data zero
            end
        end
        if (psel && penable && pready_q && pwrite && paddr == shsc_pkg::CTRL_OFS)
        begin
            ctrl_d = pwdata[2:0];
        end
    end

    // bus registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= shsc_pkg::CTRL_RESET;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stop_osc_off: assert property ((state_q == shsc_pkg::SHSC_RUN) && entry_req && !entry_block
        && instr_is_stop |=> !osc_enable_q && !cpu_clk_enable_q)
        else $error("oscillator not halted on stop entry");
    a_halt_cpu_gate: assert property ((state_q == shsc_pkg::SHSC_RUN) && entry_req && !entry_block
        && instr_is_halt && !instr_is_stop |=> osc_enable_q && !cpu_clk_enable_q)
        else $error("halt entry clock gating wrong");
    a_halt_resume_now: assert property ((state_q == shsc_pkg::SHSC_HALT) && halt_wake
        |=> cpu_clk_enable_q && resume_q && comparator_undefined_q)
        else $error("halt wake did not resume at once");
    a_timer_stop_clear: assert property ((state_q == shsc_pkg::SHSC_STOP)
        |-> timer_clear_q && !timer_run_q)
        else $error("timer not cleared in stop");
    a_serial_stop_ext: assert property ((state_q == shsc_pkg::SHSC_STOP) && $stable(ctrl_q)
        |-> serial_run_q == ctrl_q[shsc_pkg::CTRL_EXTCLK_BIT])
        else $error("serial run wrong in stop");
    a_zero_stop_pins: assert property ((state_q == shsc_pkg::SHSC_RUN) && entry_req && !entry_block
        && instr_is_stop && instr_operand == shsc_pkg::OP_ZERO
        |=> pins_input_q && reinit_q && !state_retain_q)
        else $error("zero stop did not force inputs");
    a_pending_blocks: assert property ((state_q == shsc_pkg::SHSC_RUN) && entry_req && entry_block
        |=> state_q == shsc_pkg::SHSC_RUN && cpu_clk_enable_q)
        else $error("standby entered with pending source");
    a_stop_no_timer: assert property ((state_q == shsc_pkg::SHSC_STOP) && !any_pend
        |=> state_q == shsc_pkg::SHSC_STOP)
        else $error("stop left without enabled request");
    a_wait_length: assert property ((state_q == shsc_pkg::SHSC_WAIT)
        && (state_d == shsc_pkg::SHSC_RUN) |-> cnt_q == shsc_pkg::CNT_W'(WAIT_CYCLES - 1))
        else $error("settle wait length wrong");
endmodule : shsc_ctrl
`default_nettype wire

// [src/shsc_pkg.sv]
/*
 * shsc_pkg: constants shared by the standby halt/stop controller.
 * Assumes a 4-source interrupt request set, with index 0 as the highest priority.
 */
`default_nettype none
package shsc_pkg;
    // -------------------------------------------------------------------
    // fsm states, one-hot
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        SHSC_RUN  = 4'h1,
        SHSC_HALT = 4'h2,
        SHSC_STOP = 4'h4,
        SHSC_WAIT = 4'h8
    } shsc_state_t;

    // -------------------------------------------------------------------
    // restart kinds reported to the core
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        SHSC_RST_ZERO = 2'h0,
        SHSC_RST_NEXT = 2'h1,
        SHSC_RST_VEC  = 2'h2
    } shsc_restart_t;

    // -------------------------------------------------------------------
    // request sources and operand fields
    // -------------------------------------------------------------------
    localparam int NREQ = 4;
    localparam int EXT_IDX = 0;
    localparam int TIMER_IDX = 1;
    localparam int OP_IRQ_BIT = 3;
    localparam int OP_TMR_BIT = 1;
    localparam logic [3:0] OP_ZERO = 4'h0;

    // -------------------------------------------------------------------
    // oscillation settle wait: 256 periods of the divide-by-256 clock
    // -------------------------------------------------------------------
    localparam int unsigned WAIT_DIV = 256;
    localparam int unsigned WAIT_PERIODS = 256;
    localparam int unsigned WAIT_CYCLES = WAIT_DIV * WAIT_PERIODS;
    localparam int CNT_W = 17;

    // -------------------------------------------------------------------
    // apb register map
    // -------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam int CTRL_EXTCLK_BIT = 0;
    localparam int CTRL_EDGE_LSB = 1;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
endpackage : shsc_pkg
`default_nettype wire

// [src/shsc_edge.sv]
/*
 * shsc_edge: edge detector and request flag for the external interrupt pin.
 * Assumes the pin is already synchronous to pclk; it runs in every mode.
 */
`default_nettype none
module shsc_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    input wire logic clear,
    output logic flag_q
);
    logic pin_q;
    logic pin_d;
    logic flag_d;
    logic hit;

    // -------------------------------------------------------------------
    // edge select; any other code takes both edges
    // -------------------------------------------------------------------
    always_comb
    begin
        unique case (edge_sel)
            shsc_pkg::EDGE_RISE: hit = pin & ~pin_q;
            shsc_pkg::EDGE_FALL: hit = ~pin & pin_q;
            default: hit = pin ^ pin_q;
        endcase
        pin_d = pin;
        flag_d = hit | (flag_q & ~clear); // set beats clear
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            pin_q <= pin_d;
            flag_q <= flag_d;
        end
    end
endmodule : shsc_edge
`default_nettype wire

// [bench/shsc_core_model.sv]
/*
 * shsc_core_model: behavioural processor core issuing standby instructions.
 * Assumes one pclk; every signal changes by non-blocking assignment after a rising edge.
 */
`default_nettype none
module shsc_core_model (
    input wire logic pclk,
    output logic instr_valid,
    output logic instr_is_halt,
    output logic instr_is_stop,
    output logic [3:0] instr_operand,
    output logic [3:1] interrupt_request_flag,
    output logic [3:0] interrupt_permit_flag,
    output logic interrupts_enabled_state
);
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------------
    // idle core
    // -------------------------------------------------------------------
    initial
    begin
        {instr_valid, instr_is_halt, instr_is_stop, instr_operand} = '0;
        {interrupt_request_flag, interrupt_permit_flag, interrupts_enabled_state} = '0;
    end
    // request, permit and enable levels as software would leave them
    task automatic flags(input logic [3:1] req, input logic [3:0] prm, input logic ei);
        @(posedge pclk);
        interrupt_request_flag <= req;
        interrupt_permit_flag <= prm;
        interrupts_enabled_state <= ei;
    endtask : flags
    // a no-op goes first so earlier flag changes settle before the decision
    task automatic exec(input logic halt, input logic stop, input logic [3:0] op);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_is_halt <= 1'b0;
        instr_is_stop <= 1'b0;
        @(posedge pclk);
        instr_is_halt <= halt;
        instr_is_stop <= stop;
        instr_operand <= op;
        @(posedge pclk);
        {instr_valid, instr_is_halt, instr_is_stop} <= 3'h0;
    endtask : exec
endmodule : shsc_core_model
`default_nettype wire

// [bench/testbench.sv]
/*
 * testbench: apb and instruction driven checks of the standby controller.
 * Assumes settle wait shortened to 8 cycles; apb answers are taken at the rising edge,
 * the other outputs are sampled on the falling edge.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------------
    // signals
    // -------------------------------------------------------------------
    localparam int unsigned WAIT = 8;
    logic pclk, presetn, psel, penable, pwrite, ext_int_pin, ext_req_clear, compare_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata_q, rd;
    logic pready_q, pslverr_q, err, instr_valid, instr_is_halt, instr_is_stop;
    logic [3:0] instr_operand, interrupt_permit_flag;
    logic [3:1] interrupt_request_flag;
    logic interrupts_enabled_state, ext_req_flag_q, osc_enable_q, cpu_clk_enable_q;
    logic timer_run_q, timer_clear_q, serial_run_q, comparator_run_q, comparator_undefined_q;
    logic state_retain_q, pins_input_q, reinit_q, resume_q;
    logic [1:0] restart_kind_q, restart_vector_q;
    int num_errors, check_count, cycles, waited;

    shsc_ctrl #(.WAIT_CYCLES(WAIT)) shsc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .instr_valid, .instr_is_halt,
        .instr_is_stop, .instr_operand, .interrupt_request_flag, .interrupt_permit_flag,
        .interrupts_enabled_state, .ext_int_pin, .ext_req_clear, .compare_done,
        .ext_req_flag_q, .osc_enable_q, .cpu_clk_enable_q, .timer_run_q, .timer_clear_q,
        .serial_run_q, .comparator_run_q, .comparator_undefined_q, .state_retain_q,
        .pins_input_q, .reinit_q, .resume_q, .restart_kind_q, .restart_vector_q);
    shsc_core_model shsc_core_model_i (.pclk, .instr_valid, .instr_is_halt, .instr_is_stop,
        .instr_operand, .interrupt_request_flag, .interrupt_permit_flag,
        .interrupts_enabled_state);

    // -------------------------------------------------------------------
    // clock, timeout and reporting
    // -------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // the whole run is under two hundred cycles; a hang never gets near this
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            num_errors++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // -------------------------------------------------------------------
    // access tasks
    // -------------------------------------------------------------------
    // request held until pready is seen high at a rising edge; no latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_q !== 1'b1);
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // bounded wait for the core clock to return, then the restart kind
    task automatic wait_resume(input logic [1:0] kind);
        waited = 0;
        do
        begin
            @(negedge pclk);
            waited++;
        end
        while (resume_q !== 1'b1 && waited < 40);
        check("resume", resume_q, 1'b1);
        check("restart kind", restart_kind_q, kind);
    endtask : wait_resume
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_resume(2'h0);
        check("settle wait", waited >= WAIT && waited <= WAIT + 4, 1'b1);
    endtask : do_reset
    // ten quiet cycles: a wrongly taken wake has shown itself by then
    task automatic idle_wait();
        repeat (10) @(negedge pclk);
    endtask : idle_wait

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, ext_int_pin, ext_req_clear, compare_done} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_resume(2'h0);
        check("settle wait", waited >= WAIT && waited <= WAIT + 4, 1'b1);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", rd, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        check("unmapped err", err, 1'b1);
        // halt with any-request wake, interrupts disabled
        shsc_core_model_i.flags(3'h0, 4'h4, 1'b0);
        shsc_core_model_i.exec(1'b1, 1'b0, 4'h8);
        @(negedge pclk);
        check("cpu clk halt", cpu_clk_enable_q, 1'b0);
        check("osc halt", osc_enable_q, 1'b1);
        check("timer halt", timer_run_q, 1'b1);
        check("serial halt", serial_run_q, 1'b1);
        check("comparator halt", comparator_run_q, 1'b0);
        check("retain halt", state_retain_q, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        check("status halt", rd, 32'h82);
        shsc_core_model_i.flags(3'h2, 4'h4, 1'b0);
        wait_resume(2'h1);
        check("no halt wait", waited <= 4, 1'b1);
        check("cmp undefined", comparator_undefined_q, 1'b1);
        @(posedge pclk);
        compare_done <= 1'b1;
        @(posedge pclk);
        compare_done <= 1'b0;
        @(negedge pclk);
        check("cmp defined", comparator_undefined_q, 1'b0);
        // pending enabled request blocks both entries; look in the very next cycle,
        // since a wrongly taken entry would be woken again at once
        shsc_core_model_i.exec(1'b1, 1'b0, 4'h8);
        @(negedge pclk);
        check("halt blocked", cpu_clk_enable_q, 1'b1);
        shsc_core_model_i.exec(1'b0, 1'b1, 4'h8);
        @(negedge pclk);
        check("stop blocked", osc_enable_q, 1'b1);
        // forced timer wake ignores its permit flag
        shsc_core_model_i.flags(3'h0, 4'h0, 1'b0);
        shsc_core_model_i.exec(1'b1, 1'b0, 4'h2);
        shsc_core_model_i.flags(3'h1, 4'h0, 1'b0);
        wait_resume(2'h1);
        // all-zero halt only leaves by reset
        shsc_core_model_i.flags(3'h0, 4'h0, 1'b0);
        shsc_core_model_i.exec(1'b1, 1'b0, 4'h0);
        shsc_core_model_i.flags(3'h7, 4'hF, 1'b1);
        idle_wait();
        check("halt 0000 held", cpu_clk_enable_q, 1'b0);
        shsc_core_model_i.flags(3'h0, 4'h1, 1'b1);
        do_reset();
        // stop with external shift clock, woken by a falling pin edge
        apb(1'b1, 8'h00, 32'h3);
        @(posedge pclk);
        ext_int_pin <= 1'b1; // a rise, which falling-edge mode must ignore
        shsc_core_model_i.exec(1'b0, 1'b1, 4'h8);
        @(negedge pclk);
        check("osc stop", osc_enable_q, 1'b0);
        check("timer stop", {timer_run_q, timer_clear_q}, 2'h1);
        check("serial ext", serial_run_q, 1'b1);
        check("retain stop", {state_retain_q, pins_input_q}, 2'h2);
        shsc_core_model_i.flags(3'h1, 4'h1, 1'b1);
        idle_wait();
        check("timer no wake", osc_enable_q, 1'b0);
        @(posedge pclk);
        ext_int_pin <= 1'b0;
        wait_resume(2'h2);
        check("pin flag", ext_req_flag_q, 1'b1);
        check("vector", restart_vector_q, 2'h0);
        check("stop settle", waited >= WAIT, 1'b1);
        @(posedge pclk);
        ext_req_clear <= 1'b1;
        @(posedge pclk);
        ext_req_clear <= 1'b0;
        // the pin flag output trails the internal flag by one cycle
        repeat (2) @(negedge pclk);
        check("pin flag clear", ext_req_flag_q, 1'b0);
        // stop with internal shift clock, woken by request 3
        apb(1'b1, 8'h00, 32'h0);
        shsc_core_model_i.flags(3'h0, 4'h8, 1'b0);
        shsc_core_model_i.exec(1'b0, 1'b1, 4'h8);
        @(negedge pclk);
        check("serial int", serial_run_q, 1'b0);
        shsc_core_model_i.flags(3'h4, 4'h8, 1'b0);
        wait_resume(2'h1);
        // all-zero stop reinitialises and floats every pin to input
        shsc_core_model_i.flags(3'h0, 4'h8, 1'b0);
        shsc_core_model_i.exec(1'b0, 1'b1, 4'h0);
        @(negedge pclk);
        check("reinit", reinit_q, 1'b1);
        check("pins input", {pins_input_q, state_retain_q}, 2'h2);
        shsc_core_model_i.flags(3'h4, 4'h8, 1'b1);
        idle_wait();
        check("stop 0000 held", osc_enable_q, 1'b0);
        do_reset();
        results();
    end
endmodule : testbench
`default_nettype wire
